// File: core/hdu_baud_gen.sv
// Oversample tick divider selected by baud_sel
`timescale 1ns/1ps
`include "hdu_regs.svh"

module hdu_baud_gen #(
    parameter int OVERSAMPLE = `HDU_OVERSAMPLE
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [2:0] baud_sel,
    output logic tick
);
    // ------------------------------------------------------------------
    // Divisor lookup
    // ------------------------------------------------------------------
    logic [9:0] count_reg;
    logic [9:0] period;
    logic run;

    generate
        if (OVERSAMPLE != 8)
        begin : g_bad
            $error("hdu_baud_gen: divisor table is built for 8x");
        end
    endgenerate

    // Mclk cycles per oversample state; code 7 stops the divider
    always_comb
    begin
        run = 1'b1;
        case (baud_sel)
            3'h0: period = 10'(`HDU_DIV_0 / OVERSAMPLE);
            3'h1: period = 10'(`HDU_DIV_1 / OVERSAMPLE);
            3'h2: period = 10'(`HDU_DIV_2 / OVERSAMPLE);
            3'h3: period = 10'(`HDU_DIV_3 / OVERSAMPLE);
            3'h4: period = 10'(`HDU_DIV_4 / OVERSAMPLE);
            3'h5: period = 10'(`HDU_DIV_5 / OVERSAMPLE);
            3'h6: period = 10'(`HDU_DIV_6 / OVERSAMPLE);
            default:
            begin
                period = 10'h001;
                run = 1'b0;
            end
        endcase
    end

    // Free running count; a new code applies at once
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !run)
            count_reg <= 10'h000;
        else if (count_reg >= period - 10'h001)
            count_reg <= 10'h000;
        else
            count_reg <= count_reg + 10'h001;
    end

    assign tick = run && (count_reg >= period - 10'h001);

endmodule // hdu_baud_gen

// File: core/hdu_pkg.sv
// Types shared by the serial port files
package hdu_pkg;

    // Control register image
    typedef struct packed {
        logic rx_full_flag;
        logic tx_done_flag;
        logic rx_irq_en;
        logic tx_irq_en;
        logic [2:0] baud_sel;
        logic ninth_bit;
    } hdu_ctrl_t;

    // Receiver states, Gray coded along the frame
    typedef enum logic [1:0] {
        HDU_RX_IDLE = 2'b00,
        HDU_RX_START = 2'b01,
        HDU_RX_DATA = 2'b11,
        HDU_RX_STOP = 2'b10
    } hdu_rx_state_t;

endpackage

// File: core/hdu_regs.svh
// Register map, field positions, reset values and divisors of the serial port
`ifndef HDU_REGS_SVH
`define HDU_REGS_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define HDU_DATA_IDX 10'h0d6
`define HDU_CTRL_IDX 10'h0d7
`define HDU_DATA_ADDR {`HDU_DATA_IDX, 2'b00}
`define HDU_CTRL_ADDR {`HDU_CTRL_IDX, 2'b00}

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define HDU_RX_FULL_BIT 7
`define HDU_TX_DONE_BIT 6
`define HDU_RX_IEN_BIT 5
`define HDU_TX_IEN_BIT 4
`define HDU_BAUD_MSB 3
`define HDU_BAUD_LSB 1
`define HDU_NINTH_BIT 0
`define HDU_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Clock divisors per baud_sel code, and bus responses
// ----------------------------------------------------------------------
`define HDU_DIV_0 6656
`define HDU_DIV_1 3328
`define HDU_DIV_2 1664
`define HDU_DIV_3 832
`define HDU_DIV_4 416
`define HDU_DIV_5 256
`define HDU_DIV_6 208
`define HDU_OVERSAMPLE 8
`define HDU_RESP_OKAY 2'b00
`define HDU_RESP_SLVERR 2'b10

`endif

// File: core/hdu_rx_vote.sv
// Two-of-three majority vote over three mid-bit samples
`timescale 1ns/1ps

module hdu_rx_vote #(
    parameter logic [2:0] SAMPLE_A = 3'h3,
    parameter logic [2:0] SAMPLE_B = 3'h4,
    parameter logic [2:0] SAMPLE_C = 3'h5
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic [2:0] phase,
    input wire logic rx_in,
    output logic bit_value
);
    logic first_reg;
    logic second_reg;
    logic bit_reg;

    // Hold the first two samples, decide on the third
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            first_reg <= 1'b1;
            second_reg <= 1'b1;
            bit_reg <= 1'b1;
        end
        else if (tick)
        begin
            if (phase == SAMPLE_A)
                first_reg <= rx_in;
            if (phase == SAMPLE_B)
                second_reg <= rx_in;
            if (phase == SAMPLE_C)
                bit_reg <= (first_reg & second_reg) | (first_reg & rx_in)
                    | (second_reg & rx_in);
        end
    end

    assign bit_value = bit_reg;

endmodule // hdu_rx_vote

// File: core/hdu_uart.sv
// Half-duplex 9-bit serial port with AXI4-Lite register access
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "hdu_regs.svh"

// Behaviour
// [R01] Watch for falling edge when not transmitting
// [R02] Wait one eight-state bit for start
// [R03] Received ninth bit overwrites ninth_bit field
// [R04] After nine bits wait stop, then buffer
// [R05] Buffer load sets rx_full_flag, maybe interrupt
// [R06] Transmit start abandons any running reception
// [R07] Data write loads shifter, starts, clears done
// [R08] Data read returns receive buffer
// [R09] Software avoids read-modify-write on data register
// [R10] baud_sel picks divisor, code seven reserved
// [R11] baud_sel change applies immediately
// [R12] Control register bit layout at D7h
// [R13] rx_full_flag writable zero or one
// [R14] tx_done_flag set at end, cleared by writes
// [R15] rx_irq_en gates receive interrupt only
// [R16] tx_irq_en gates transmit interrupt only
// [R17] Interrupt is OR of enabled flags
// [R18] ninth_bit writes transmit level, reads received
// [R19] Eight states per bit, majority vote
// [R20] Frame: start, eight lsb-first, ninth, stop
// [R21] Pin follows transmitter only while sending
// [R22] Reset clears flags, enables, fields; idle
module hdu_uart #(
    parameter int OVERSAMPLE = `HDU_OVERSAMPLE,
    parameter int DATA_BITS = 9
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_in,
    input wire logic port_level,
    output logic tx_pin,
    output logic tx_out_select,
    output logic irq
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [2:0] PH_LAST = 3'(OVERSAMPLE - 1);
    localparam logic [3:0] RX_LAST_BIT = 4'(DATA_BITS - 1);
    localparam logic [3:0] TX_LAST_BIT = 4'(DATA_BITS + 1);

    hdu_pkg::hdu_ctrl_t ctrl_reg;
    hdu_pkg::hdu_rx_state_t rx_state_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [11:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] rx_buf_reg;
    logic [8:0] rx_shift_reg;
    logic [2:0] rx_phase_reg;
    logic [3:0] rx_cnt_reg;
    logic rx_prev_reg;
    logic [10:0] tx_shift_reg;
    logic [2:0] tx_phase_reg;
    logic [3:0] tx_cnt_reg;
    logic tx_active_reg;
    logic tick;
    logic voted_bit;
    logic do_write;
    logic write_mapped;
    logic wr_data;
    logic wr_ctrl;
    logic rd_take;
    logic rx_fall;
    logic rx_done;
    logic tx_start;
    logic tx_finish;

    generate
        if (OVERSAMPLE < 6 || OVERSAMPLE > 8 || DATA_BITS != 9)
        begin : g_bad
            $error("hdu_uart: unsupported oversample or frame width");
        end
    endgenerate

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign write_mapped = (aw_addr_reg == `HDU_DATA_ADDR)
        || (aw_addr_reg == `HDU_CTRL_ADDR);
    assign wr_data = do_write && w_lane_reg
        && (aw_addr_reg == `HDU_DATA_ADDR);
    assign wr_ctrl = do_write && w_lane_reg
        && (aw_addr_reg == `HDU_CTRL_ADDR);

    // Address and data are caught in either order
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && !w_held_reg)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `HDU_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= write_mapped ? `HDU_RESP_OKAY : `HDU_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign rd_take = s_axi_arvalid && !rvalid_reg;

    // Reads have no side effects; data address shows the buffer
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `HDU_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= `HDU_RESP_OKAY;
            if (s_axi_araddr == `HDU_DATA_ADDR)
                rdata_reg <= {24'h000000, rx_buf_reg}; // R08
            else if (s_axi_araddr == `HDU_CTRL_ADDR)
                rdata_reg <= {24'h000000, ctrl_reg}; // R12 R18
            else
            begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= `HDU_RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Software writes first, hardware sets override in the same cycle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            ctrl_reg <= hdu_pkg::hdu_ctrl_t'(`HDU_CTRL_RESET); // R22
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_reg.rx_full_flag <= w_data_reg[`HDU_RX_FULL_BIT]; // R13
                ctrl_reg.tx_done_flag <= w_data_reg[`HDU_TX_DONE_BIT]; // R14
                ctrl_reg.rx_irq_en <= w_data_reg[`HDU_RX_IEN_BIT]; // R15
                ctrl_reg.tx_irq_en <= w_data_reg[`HDU_TX_IEN_BIT]; // R16
                ctrl_reg.baud_sel <=
                    w_data_reg[`HDU_BAUD_MSB:`HDU_BAUD_LSB]; // R11
                ctrl_reg.ninth_bit <= w_data_reg[`HDU_NINTH_BIT]; // R18
            end
            if (wr_data)
                ctrl_reg.tx_done_flag <= 1'b0; // R07
            if (tx_finish)
                ctrl_reg.tx_done_flag <= 1'b1; // R14
            if (rx_done)
            begin
                ctrl_reg.rx_full_flag <= 1'b1; // R05
                ctrl_reg.ninth_bit <= rx_shift_reg[8]; // R03
            end
        end
    end

    // Interrupt request from enabled flags
    assign irq = (ctrl_reg.rx_full_flag && ctrl_reg.rx_irq_en)
        || (ctrl_reg.tx_done_flag && ctrl_reg.tx_irq_en); // R17

    // ------------------------------------------------------------------
    // Oversample clock and bit vote
    // ------------------------------------------------------------------
    hdu_baud_gen #(
        .OVERSAMPLE(OVERSAMPLE)
    ) u_baud (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .baud_sel(ctrl_reg.baud_sel), // R10 R11
        .tick(tick)
    );

    hdu_rx_vote u_vote (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick),
        .phase(rx_phase_reg),
        .rx_in(rx_in),
        .bit_value(voted_bit) // R19
    );

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    assign rx_fall = rx_prev_reg && !rx_in;
    assign rx_done = (rx_state_reg == hdu_pkg::HDU_RX_STOP) && tick
        && (rx_phase_reg == PH_LAST); // R04

    // Previous line level for edge detection
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rx_prev_reg <= 1'b1;
        else
            rx_prev_reg <= rx_in;
    end

    // Frame walk: start wait, nine bits, stop wait
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rx_state_reg <= hdu_pkg::HDU_RX_IDLE; // R22
            rx_phase_reg <= 3'h0;
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
        end
        else if (tx_start || tx_active_reg)
            rx_state_reg <= hdu_pkg::HDU_RX_IDLE; // R06
        else
        begin
            case (rx_state_reg)
                hdu_pkg::HDU_RX_IDLE:
                begin
                    rx_phase_reg <= 3'h0;
                    if (rx_fall)
                        rx_state_reg <= hdu_pkg::HDU_RX_START; // R01
                end
                hdu_pkg::HDU_RX_START:
                begin
                    if (tick)
                    begin
                        rx_phase_reg <= rx_phase_reg + 3'h1;
                        if (rx_phase_reg == PH_LAST)
                        begin
                            rx_phase_reg <= 3'h0;
                            rx_cnt_reg <= 4'h0;
                            rx_state_reg <= hdu_pkg::HDU_RX_DATA; // R02
                        end
                    end
                end
                hdu_pkg::HDU_RX_DATA:
                begin
                    if (tick)
                    begin
                        rx_phase_reg <= rx_phase_reg + 3'h1;
                        if (rx_phase_reg == PH_LAST)
                        begin
                            rx_phase_reg <= 3'h0;
                            rx_shift_reg <= {voted_bit, rx_shift_reg[8:1]};
                            rx_cnt_reg <= rx_cnt_reg + 4'h1;
                            if (rx_cnt_reg == RX_LAST_BIT)
                                rx_state_reg <= hdu_pkg::HDU_RX_STOP;
                        end
                    end
                end
                hdu_pkg::HDU_RX_STOP:
                begin
                    if (tick)
                    begin
                        rx_phase_reg <= rx_phase_reg + 3'h1;
                        if (rx_phase_reg == PH_LAST)
                        begin
                            rx_phase_reg <= 3'h0;
                            rx_state_reg <= hdu_pkg::HDU_RX_IDLE; // R04
                        end
                    end
                end
                default: rx_state_reg <= hdu_pkg::HDU_RX_IDLE;
            endcase
        end
    end

    // Receive buffer frees the shifter for the next character
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rx_buf_reg <= 8'h00;
        else if (rx_done)
            rx_buf_reg <= rx_shift_reg[7:0]; // R04
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    assign tx_start = wr_data;
    assign tx_finish = tx_active_reg && tick && (tx_phase_reg == PH_LAST)
        && (tx_cnt_reg == TX_LAST_BIT);

    // Shift out start, eight data lsb first, ninth, stop
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tx_active_reg <= 1'b0;
            tx_shift_reg <= 11'h7ff;
            tx_phase_reg <= 3'h0;
            tx_cnt_reg <= 4'h0;
        end
        else if (tx_start)
        begin
            tx_active_reg <= 1'b1; // R07
            tx_shift_reg <= {1'b1, ctrl_reg.ninth_bit, w_data_reg,
                1'b0}; // R20
            tx_phase_reg <= 3'h0;
            tx_cnt_reg <= 4'h0;
        end
        else if (tx_active_reg && tick)
        begin
            tx_phase_reg <= tx_phase_reg + 3'h1;
            if (tx_phase_reg == PH_LAST)
            begin
                tx_phase_reg <= 3'h0;
                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
                if (tx_cnt_reg == TX_LAST_BIT)
                    tx_active_reg <= 1'b0;
            end
        end
    end

    // Output multiplexer between transmitter and port level
    assign tx_out_select = tx_active_reg; // R21
    assign tx_pin = tx_active_reg ? tx_shift_reg[0] : port_level; // R21

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_start_edge_seen: assert property (@(posedge mclk) disable iff (sys_rst) // R01
        (rx_state_reg == hdu_pkg::HDU_RX_IDLE && rx_fall && !tx_start
        && !tx_active_reg) |=> rx_state_reg == hdu_pkg::HDU_RX_START)
        else $error("start edge not taken");

    a_start_bit_wait: assert property (@(posedge mclk) disable iff (sys_rst) // R02
        $rose(rx_state_reg == hdu_pkg::HDU_RX_DATA) |->
        $past(rx_state_reg) == hdu_pkg::HDU_RX_START
        && $past(rx_phase_reg) == 3'h7 && rx_cnt_reg == 4'h0)
        else $error("data phase entered before eight states");

    a_ninth_copy: assert property (@(posedge mclk) disable iff (sys_rst) // R03
        rx_done |=> ctrl_reg.ninth_bit == $past(rx_shift_reg[8]))
        else $error("ninth bit not copied");

    a_buffer_load: assert property (@(posedge mclk) disable iff (sys_rst) // R04
        rx_done |=> rx_buf_reg == $past(rx_shift_reg[7:0])
        && ctrl_reg.rx_full_flag && rx_state_reg == hdu_pkg::HDU_RX_IDLE)
        else $error("buffer not loaded after stop");

    a_tx_priority: assert property (@(posedge mclk) disable iff (sys_rst) // R06
        tx_start |=> rx_state_reg == hdu_pkg::HDU_RX_IDLE && tx_active_reg)
        else $error("reception not abandoned on transmit");

    a_data_write: assert property (@(posedge mclk) disable iff (sys_rst) // R07
        (tx_start && !tx_finish) |=> !ctrl_reg.tx_done_flag
        && tx_pin == 1'b0 && tx_out_select)
        else $error("data write did not start transmit");

    a_read_buffer: assert property (@(posedge mclk) disable iff (sys_rst) // R08
        (rd_take && s_axi_araddr == `HDU_DATA_ADDR) |=>
        s_axi_rvalid && s_axi_rdata[7:0] == $past(rx_buf_reg))
        else $error("data read not from buffer");

    a_tx_frame_len: assert property (@(posedge mclk) disable iff (sys_rst) // R20
        tx_finish |-> tx_cnt_reg == 4'ha && tx_shift_reg[0] == 1'b1
        ##1 (ctrl_reg.tx_done_flag && (!tx_out_select || $past(tx_start))))
        else $error("frame length or stop level wrong");

    a_irq_output: assert property (@(posedge mclk) disable iff (sys_rst) // R17
        (ctrl_reg.tx_done_flag && ctrl_reg.tx_irq_en) |-> irq)
        else $error("enabled flag gives no interrupt");

    a_pin_route: assert property (@(posedge mclk) disable iff (sys_rst) // R21
        !tx_out_select |-> tx_pin == port_level)
        else $error("pin not following port level");

    a_reset_clear: assert property (@(posedge mclk) // R22
        sys_rst |=> ctrl_reg == 8'h00 && rx_state_reg == hdu_pkg::HDU_RX_IDLE)
        else $error("reset state wrong");

    c_rx_frame: cover property (@(posedge mclk) disable iff (sys_rst)
        rx_done);
    c_tx_frame: cover property (@(posedge mclk) disable iff (sys_rst)
        tx_finish);
    c_tx_preempt: cover property (@(posedge mclk) disable iff (sys_rst)
        tx_start && rx_state_reg == hdu_pkg::HDU_RX_DATA);

endmodule // hdu_uart

// File: dv/hdu_remote_node.sv
// Remote serial node: sends frames to the port and captures its frames
`timescale 1ns/1ps

module hdu_remote_node #(
    parameter int BIT_CYC = 208
) (
    input wire logic mclk,
    output logic rx_line,
    input wire logic tx_line
);
    // -------------------------------------------------------------
    // Line idles high between frames
    // -------------------------------------------------------------
    initial rx_line = 1'b1;

    // Start low, nine bits lsb first, stop high
    task automatic send(input logic [8:0] d);
        logic [10:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rx_line <= f[i];
            repeat (BIT_CYC) @(posedge mclk);
        end
    endtask

    // Sample each bit near its middle after the start edge
    task automatic get(output logic [8:0] d);
        while (tx_line !== 1'b0) @(posedge mclk);
        repeat (BIT_CYC / 2) @(posedge mclk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_CYC) @(posedge mclk);
            d[i] = tx_line;
        end
    endtask
endmodule // hdu_remote_node

// File: dv/test_half_duplex_uart_rx_and_regs.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "hdu_regs.svh"

module test_half_duplex_uart_rx_and_regs;
    logic mclk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_in, port_level;
    logic tx_pin, tx_out_select, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [8:0] got;
    int fails, checks;

    hdu_uart DUT (.*);
    hdu_remote_node node (.mclk(mclk), .rx_line(rx_in), .tx_line(tx_pin));

    // -------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // -------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Cut a hang short
    initial
    begin
        #300000;
        fails++;
        stop_test();
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // -------------------------------------------------------------
    // Test sequence
    // -------------------------------------------------------------
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h1;
        port_level = 1'b1;
        sys_rst = 1'b1;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`HDU_CTRL_ADDR);
        chk(d, 32'h0);
        chk({irq, tx_out_select}, 2'h0);
        rd(12'h000);
        chk({30'h0, r}, {30'h0, `HDU_RESP_SLVERR});
        // Fastest rate, ninth bit high, transmit interrupt on
        wr(`HDU_CTRL_ADDR, 8'h1d);
        chk({30'h0, r}, {30'h0, `HDU_RESP_OKAY});
        rd(`HDU_CTRL_ADDR);
        chk(d, 32'h1d);
        wr(`HDU_DATA_ADDR, 8'ha5);
        node.get(got);
        chk({23'h0, got}, {23'h0, 9'h1a5});
        chk({31'h0, tx_out_select}, 32'h1);
        repeat (400) @(posedge mclk);
        chk({tx_out_select, tx_pin}, 2'h1);
        rd(`HDU_CTRL_ADDR);
        chk(d, 32'h5d);
        chk({31'h0, irq}, 32'h1);
        // A data write clears the done flag and sends again
        wr(`HDU_DATA_ADDR, 8'h3c);
        rd(`HDU_CTRL_ADDR);
        chk(d, 32'h1d);
        node.get(got);
        chk({23'h0, got}, {23'h0, 9'h13c});
        repeat (400) @(posedge mclk);
        wr(`HDU_CTRL_ADDR, 8'h0d);
        rd(`HDU_CTRL_ADDR);
        chk({d[7:0], 7'h0, irq}, {8'h0d, 8'h00});
        // Reception overwrites ninth bit and fills the buffer
        node.send({1'b0, 8'h96});
        repeat (400) @(posedge mclk);
        rd(`HDU_CTRL_ADDR);
        chk({d[7:0], 7'h0, irq}, {8'h8c, 8'h00});
        rd(`HDU_DATA_ADDR);
        chk(d, 32'h96);
        wr(`HDU_CTRL_ADDR, 8'hac);
        chk({31'h0, irq}, 32'h1);
        wr(`HDU_CTRL_ADDR, 8'h2c);
        rd(`HDU_CTRL_ADDR);
        chk({d[7:0], 7'h0, irq}, {8'h2c, 8'h00});
        // A transmit started mid-reception abandons the reception
        fork
            node.send(9'h1f0);
            begin
                repeat (600) @(posedge mclk);
                wr(`HDU_DATA_ADDR, 8'h5a);
                node.get(got);
            end
        join
        chk({23'h0, got}, {23'h0, 9'h05a});
        repeat (400) @(posedge mclk);
        rd(`HDU_CTRL_ADDR);
        chk({d[7:0], 7'h0, irq}, {8'h6c, 8'h00});
        // Reserved rate code stops the bit clock at once
        wr(`HDU_CTRL_ADDR, 8'h2e);
        wr(`HDU_DATA_ADDR, 8'h00);
        repeat (300) @(posedge mclk);
        chk({tx_out_select, tx_pin}, 2'h2);
        stop_test();
    end
endmodule // test_half_duplex_uart_rx_and_regs
